// ==== core/chopper_pkg.sv ====
// Purpose: Shared constants for the dual bridge chopping controller.
// Assumes: A 25 MHz core clock; four-level pins arrive as two-bit codes.
// Notes:   Times are held in ns as printed; cycle counts derive from them.
package chopper_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMER_W       = 11;

  // Off-time choices, deglitch and blanking times in ns.
  localparam int OFF_TIME_LOW_NS   = 7000;
  localparam int OFF_TIME_HIGH_NS  = 16000;
  localparam int OFF_TIME_OPEN_NS  = 24000;
  localparam int OFF_TIME_RGND_NS  = 32000;
  localparam int OFF_DEGLITCH_NS   = 10000;
  localparam int BLANK_NS          = 1000;
  localparam int LONG_DRIVE_NS     = 40000;

  // Least times round up to whole cycles.
  localparam logic [10:0] OFF_LOW_CYC   = 11'((OFF_TIME_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] OFF_HIGH_CYC  = 11'((OFF_TIME_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] OFF_OPEN_CYC  = 11'((OFF_TIME_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] OFF_RGND_CYC  = 11'((OFF_TIME_RGND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] DEGLITCH_CYC  = 11'((OFF_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] BLANK_CYC     = 11'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] LONG_DRIVE_CYC = 11'((LONG_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Four-level pin codes and fast-decay fractions in tenths.
  // ----------------------------------------------------------------------
  localparam logic [1:0] LEVEL_LOW  = 2'h0;
  localparam logic [1:0] LEVEL_HIGH = 2'h1;
  localparam logic [1:0] LEVEL_OPEN = 2'h2;
  localparam logic [1:0] LEVEL_RGND = 2'h3;

  localparam logic [3:0] FRAC_FULL  = 4'ha;
  localparam logic [3:0] FRAC_MIXED = 4'h3;
  localparam logic [3:0] FRAC_RESET = 4'h3;
  localparam logic [1:0] OFF_SELECT_RESET = 2'h0;

  // Per-bridge chopping states.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DRIVE = 4'h2,
    ST_FAST  = 4'h4,
    ST_SLOW  = 4'h8
  } chop_state_type;

endpackage

// ==== core/dual_hbridge_chopper_control.sv ====
// Purpose: Command decode and off-time current chopping for two H-bridges.
// Assumes: Pin-level inputs are asynchronous; outputs feed gate drivers.
// Notes:   Each output has a high and a low switch; both off means Hi-Z.
//
// Notes on behaviour
// - Sleep low forces every bridge output Hi-Z.
// - Enable low Hi-Z; direction picks output polarity.
// - Two-input codes: brake low, reverse, forward, brake high.
// - Forward drives current from output one to two.
// - Drive until trip, decay off-time, drive again.
// - Off-time pin selects 7, 16, 24, 32 us.
// - Off-time governs all modes except ripple control.
// - New off-time applies after 10 us stable.
// - Trip comparator input marks reference over gain.
// - Fast decay reverses bridge, off near zero.
// - Slow decay turns on both low switches.
// - Decay pin: adaptive, ripple, mixed 30%, fast.
// - Each bridge uses only its own decay pin.
// - Mixed decay: fast 30% then slow rest.
// - Adaptive picks slow, mixed, fast each cycle.
// - Adaptive overshoot raises fast fraction next cycle.
// - Adaptive long drive lowers fast fraction next.
// - Adaptive downward target step uses full fast.
// - Ripple mode holds slow decay until valley.
// - Ignore trip for 1 us blanking after drive.
`timescale 1ns/1ps

module dual_hbridge_chopper_control (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Sleep and interface variant (1 selects the two-input variant).
  input  wire logic       i_sleep_request_low,
  input  wire logic       i_two_input_mode,
  // Bridge commands, bit 0 bridge A, bit 1 bridge B.
  input  wire logic [1:0] i_bridge_enable_in,
  input  wire logic [1:0] i_bridge_direction_in,
  input  wire logic [1:0] i_bridge_input_one,
  input  wire logic [1:0] i_bridge_input_two,
  // Four-level configuration pins as two-bit codes.
  input  wire logic [1:0] i_off_time_select,
  input  wire logic [1:0] i_bridge_a_decay_select,
  input  wire logic [1:0] i_bridge_b_decay_select,
  // Current comparators and target step per bridge.
  input  wire logic [1:0] i_trip_current_level,
  input  wire logic [1:0] i_valley_current_level,
  input  wire logic [1:0] i_current_near_zero,
  input  wire logic [1:0] i_target_step_down,
  // Switch commands per bridge output.
  output logic      [1:0] o_bridge_output_one_high,
  output logic      [1:0] o_bridge_output_one_low,
  output logic      [1:0] o_bridge_output_two_high,
  output logic      [1:0] o_bridge_output_two_low,
  output logic      [1:0] o_off_time_applied
);

  // ----------------------------------------------------------------------
  // Reset release and input synchronisers.
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 24;

  logic              rst_meta_reg;
  logic              rst_sync_n_reg;
  logic [SYNC_W-1:0] sync_meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic [SYNC_W-1:0] sync_raw;

  // Release reset through two flops so every state flop leaves reset together.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // Gather every pin-level input for the two-flop synchroniser.
  assign sync_raw = {i_sleep_request_low, i_two_input_mode, i_bridge_enable_in, i_bridge_direction_in,
                     i_bridge_input_one, i_bridge_input_two, i_trip_current_level, i_valley_current_level,
                     i_current_near_zero, i_target_step_down, i_off_time_select,
                     i_bridge_a_decay_select, i_bridge_b_decay_select};

  // Two flops per input; only the second stage is read below.
  always_ff @(posedge i_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      sync_meta_reg <= '0;
      sync_reg      <= '0;
    end else begin
      sync_meta_reg <= sync_raw;
      sync_reg      <= sync_meta_reg;
    end
  end

  logic       awake;
  logic       two_input;
  logic [1:0] en_s, dir_s, in1_s, in2_s, trip_s, valley_s, zero_s, step_s;
  logic [1:0] off_sel_s;
  logic [1:0] decay_sel_s [2];

  // Split the synchronised bus back into named fields.
  assign {awake, two_input, en_s, dir_s, in1_s, in2_s, trip_s, valley_s, zero_s, step_s, off_sel_s,
          decay_sel_s[0], decay_sel_s[1]} = sync_reg;

  // ----------------------------------------------------------------------
  // Off-time selection with deglitch.
  // ----------------------------------------------------------------------
  function automatic logic [10:0] off_cycles(input logic [1:0] code);
    case (code)
      chopper_pkg::LEVEL_LOW:  off_cycles = chopper_pkg::OFF_LOW_CYC;
      chopper_pkg::LEVEL_HIGH: off_cycles = chopper_pkg::OFF_HIGH_CYC;
      chopper_pkg::LEVEL_OPEN: off_cycles = chopper_pkg::OFF_OPEN_CYC;
      default:                 off_cycles = chopper_pkg::OFF_RGND_CYC;
    endcase
  endfunction

  // Fast part of a decay: off-time times tenths, rounded down.
  function automatic logic [10:0] fast_cycles(input logic [10:0] off, input logic [3:0] frac);
    logic [14:0] prod;
    prod        = 15'(off) * 15'(frac);  // Widen both factors so 800 times 10 cannot wrap.
    fast_cycles = 11'(prod / 15'd10);
  endfunction

  logic [1:0]  off_cand_reg, off_cand_next;
  logic [1:0]  off_applied_reg, off_applied_next;
  logic [10:0] stable_cnt_reg, stable_cnt_next;
  logic [10:0] off_len;

  // A new code must stay unchanged for the deglitch time before it is used.
  always_comb begin
    off_cand_next    = off_sel_s;
    off_applied_next = off_applied_reg;
    stable_cnt_next  = stable_cnt_reg;
    if (off_sel_s != off_cand_reg) begin
      stable_cnt_next = 11'h000;
    end else if (off_cand_reg != off_applied_reg) begin
      if (stable_cnt_reg >= chopper_pkg::DEGLITCH_CYC - 11'h001) begin
        off_applied_next = off_cand_reg;
        stable_cnt_next  = 11'h000;
      end else begin
        stable_cnt_next = stable_cnt_reg + 11'h001;
      end
    end
  end

  // Register the off-time selection state.
  always_ff @(posedge i_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      off_cand_reg    <= chopper_pkg::OFF_SELECT_RESET;
      off_applied_reg <= chopper_pkg::OFF_SELECT_RESET;
      stable_cnt_reg  <= 11'h000;
    end else begin
      off_cand_reg    <= off_cand_next;
      off_applied_reg <= off_applied_next;
      stable_cnt_reg  <= stable_cnt_next;
    end
  end

  assign off_len            = off_cycles(off_applied_reg);
  assign o_off_time_applied = off_applied_reg;

  // ----------------------------------------------------------------------
  // Per-bridge command decode and chopping machine.
  // ----------------------------------------------------------------------
  for (genvar b = 0; b < 2; b++) begin : g_bridge
    chopper_pkg::chop_state_type state_reg, state_next;
    logic [10:0] timer_reg, timer_next;
    logic [10:0] fast_len_reg, fast_len_next;
    logic [3:0]  frac_reg, frac_next;
    logic        step_pend_reg, step_pend_next;
    logic        step_prev_reg;
    logic        zero_reg, zero_next;
    logic [3:0]  out_reg, out_next;
    logic        drive_cmd, fwd, brake_low, brake_high;
    logic [1:0]  mode;
    logic [3:0]  frac_use;

    // Decode the commands of either interface variant.
    always_comb begin
      if (two_input) begin
        drive_cmd  = in1_s[b] ^ in2_s[b];
        fwd        = in1_s[b];
        brake_low  = !in1_s[b] && !in2_s[b];
        brake_high = in1_s[b] && in2_s[b];
      end else begin
        drive_cmd  = en_s[b];
        fwd        = dir_s[b];
        brake_low  = 1'b0;
        brake_high = 1'b0;
      end
    end

    assign mode = decay_sel_s[b];

    // Chopping sequence: drive, blank, trip, decay, drive again.
    always_comb begin
      state_next     = state_reg;
      timer_next     = timer_reg;
      fast_len_next  = fast_len_reg;
      frac_next      = frac_reg;
      zero_next      = zero_reg;
      frac_use       = frac_reg;
      step_pend_next = step_pend_reg;
      case (state_reg)
        chopper_pkg::ST_IDLE: begin
          if (drive_cmd) begin
            state_next = chopper_pkg::ST_DRIVE;
            timer_next = 11'h000;
          end
        end
        chopper_pkg::ST_DRIVE: begin
          if (timer_reg != 11'h7ff) begin
            timer_next = timer_reg + 11'h001;
          end
          // Trip is honoured only once the blanking time has run.
          if (timer_reg >= chopper_pkg::BLANK_CYC && trip_s[b]) begin
            timer_next = 11'h000;
            zero_next  = 1'b0;
            if (timer_reg == chopper_pkg::BLANK_CYC && frac_reg != chopper_pkg::FRAC_FULL) begin
              frac_use = frac_reg + 4'h1;
            end else if (timer_reg >= chopper_pkg::LONG_DRIVE_CYC && frac_reg != 4'h0) begin
              frac_use = frac_reg - 4'h1;
            end
            if (step_pend_reg) begin
              step_pend_next = 1'b0;
            end
            case (mode)
              chopper_pkg::LEVEL_LOW: begin
                frac_next     = frac_use;
                fast_len_next = step_pend_reg ? off_len : fast_cycles(off_len, frac_use);
              end
              chopper_pkg::LEVEL_HIGH: fast_len_next = 11'h000;
              chopper_pkg::LEVEL_OPEN: fast_len_next = fast_cycles(off_len, chopper_pkg::FRAC_MIXED);
              default:                 fast_len_next = off_len;
            endcase
            state_next = (fast_len_next != 11'h000) ? chopper_pkg::ST_FAST : chopper_pkg::ST_SLOW;
          end
        end
        chopper_pkg::ST_FAST: begin
          timer_next = timer_reg + 11'h001;
          if (zero_s[b]) begin
            zero_next = 1'b1;
          end
          if (timer_reg >= off_len - 11'h001) begin
            state_next = chopper_pkg::ST_DRIVE;
            timer_next = 11'h000;
          end else if (timer_reg >= fast_len_reg - 11'h001) begin
            state_next = chopper_pkg::ST_SLOW;
          end
        end
        chopper_pkg::ST_SLOW: begin
          timer_next = timer_reg + 11'h001;
          if (mode == chopper_pkg::LEVEL_HIGH) begin
            if (valley_s[b]) begin
              state_next = chopper_pkg::ST_DRIVE;
              timer_next = 11'h000;
            end
          end else if (timer_reg >= off_len - 11'h001) begin
            state_next = chopper_pkg::ST_DRIVE;
            timer_next = 11'h000;
          end
        end
        default: begin
          state_next = chopper_pkg::ST_IDLE;
        end
      endcase
      // A dropped command or sleep leaves chopping at once.
      if (!drive_cmd || !awake) begin
        state_next = chopper_pkg::ST_IDLE;
        timer_next = 11'h000;
      end
      // A target step arriving with the clear is kept pending.
      if (step_s[b] && !step_prev_reg) begin
        step_pend_next = 1'b1;
      end
    end

    // Switch pattern {one high, one low, two high, two low} for the next state.
    always_comb begin
      out_next = 4'h0;
      case (state_next)
        chopper_pkg::ST_DRIVE: out_next = fwd ? 4'h9 : 4'h6;
        chopper_pkg::ST_FAST:  out_next = zero_next ? 4'h0 : (fwd ? 4'h6 : 4'h9);
        chopper_pkg::ST_SLOW:  out_next = 4'h5;
        chopper_pkg::ST_IDLE:  out_next = brake_low ? 4'h5 : (brake_high ? 4'ha : 4'h0);
        default:               out_next = 4'h0;
      endcase
      if (!awake) begin
        out_next = 4'h0;
      end
    end

    // Register the chopping state and the switch commands.
    always_ff @(posedge i_clk or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
        state_reg     <= chopper_pkg::ST_IDLE;
        timer_reg     <= 11'h000;
        fast_len_reg  <= 11'h000;
        frac_reg      <= chopper_pkg::FRAC_RESET;
        step_pend_reg <= 1'b0;
        step_prev_reg <= 1'b0;
        zero_reg      <= 1'b0;
        out_reg       <= 4'h0;
      end else begin
        state_reg     <= state_next;
        timer_reg     <= timer_next;
        fast_len_reg  <= fast_len_next;
        frac_reg      <= frac_next;
        step_pend_reg <= step_pend_next;
        step_prev_reg <= step_s[b];
        zero_reg      <= zero_next;
        out_reg       <= out_next;
      end
    end

    assign o_bridge_output_one_high[b] = out_reg[3];
    assign o_bridge_output_one_low[b]  = out_reg[2];
    assign o_bridge_output_two_high[b] = out_reg[1];
    assign o_bridge_output_two_low[b]  = out_reg[0];
  end

endmodule

// ==== dv/chopper_checker.sv ====
// Purpose: Port-level assertions for the bridge chopping controller.
// Assumes: Three cycles pass from an input change to the switch outputs.
// Notes:   Patterns are {one_high, one_low, two_high, two_low}.
`timescale 1ns/1ps
module chopper_checker (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_sleep_request_low,
  input wire logic       i_two_input_mode,
  input wire logic [1:0] i_bridge_enable_in,
  input wire logic [1:0] i_bridge_direction_in,
  input wire logic [1:0] i_bridge_input_one,
  input wire logic [1:0] i_bridge_input_two,
  input wire logic [1:0] i_off_time_select,
  input wire logic [1:0] o_bridge_output_one_high,
  input wire logic [1:0] o_bridge_output_one_low,
  input wire logic [1:0] o_bridge_output_two_high,
  input wire logic [1:0] o_bridge_output_two_low,
  input wire logic [1:0] o_off_time_applied
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] pa;
  logic [3:0] pb;
  logic [5:0] cmd_a;
  logic [9:0] run_reg;
  logic [9:0] calm_reg;
  logic [9:0] sel_reg;
  // Switch patterns of each bridge and the commands that steer bridge A.
  assign pa = {o_bridge_output_one_high[0], o_bridge_output_one_low[0], o_bridge_output_two_high[0],
               o_bridge_output_two_low[0]};
  assign pb = {o_bridge_output_one_high[1], o_bridge_output_one_low[1], o_bridge_output_two_high[1],
               o_bridge_output_two_low[1]};
  assign cmd_a = {i_sleep_request_low, i_two_input_mode, i_bridge_enable_in[0], i_bridge_direction_in[0],
                  i_bridge_input_one[0], i_bridge_input_two[0]};
  // Saturating counts of forward drive on A, of steady commands and of a steady off-time pin.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg  <= 10'h0;
      calm_reg <= 10'h0;
      sel_reg  <= 10'h0;
    end else begin
      run_reg  <= (pa != 4'h9) ? 10'h0 : run_reg + 10'(run_reg != 10'h3ff);
      calm_reg <= $changed(cmd_a) ? 10'h0 : calm_reg + 10'(calm_reg != 10'h3ff);
      sel_reg  <= $changed(i_off_time_select) ? 10'h0 : sel_reg + 10'(sel_reg != 10'h3ff);
    end
  end
  sequence s_asleep;
    !i_sleep_request_low [*4];
  endsequence
  a_sleep_all_off: assert property (s_asleep |-> {pa, pb} == 8'h00)
    else $error("switch on while asleep");
  a_enable_off_a: assert property (
    (i_sleep_request_low && !i_two_input_mode && !i_bridge_enable_in[0]) [*4] |-> pa == 4'h0)
    else $error("bridge A on while disabled");
  a_enable_off_b: assert property (
    (i_sleep_request_low && !i_two_input_mode && !i_bridge_enable_in[1]) [*4] |-> pb == 4'h0)
    else $error("bridge B on while disabled");
  a_brake_low_pair: assert property (
    (i_sleep_request_low && i_two_input_mode && !i_bridge_input_one[0] && !i_bridge_input_two[0]) [*4]
    |-> pa == 4'h5) else $error("low brake pattern wrong");
  a_brake_high_pair: assert property (
    (i_sleep_request_low && i_two_input_mode && i_bridge_input_one[0] && i_bridge_input_two[0]) [*4]
    |-> pa == 4'ha) else $error("high brake pattern wrong");
  a_no_high_pair: assert property (!i_two_input_mode [*4] |-> pa != 4'ha)
    else $error("both high switches on in direction mode");
  a_blank_drive: assert property ($fell(pa == 4'h9) && calm_reg >= 10'd30 |-> run_reg >= 10'd26)
    else $error("drive ended inside blanking");
  a_deglitch_hold: assert property ($changed(o_off_time_applied) |->
    $past(sel_reg, 3) >= 10'd245 && $past(i_off_time_select, 3) == o_off_time_applied)
    else $error("off-time taken before steady");
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the bridge chopping controller.
// Assumes: Inputs change 2 ns after a rising edge; outputs are read there too.
// Notes:   Decay lengths are counted in cycles of the switch patterns.
`timescale 1ns/1ps
bind dual_hbridge_chopper_control chopper_checker u_chopper_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sleep_request_low(i_sleep_request_low),
  .i_two_input_mode(i_two_input_mode), .i_bridge_enable_in(i_bridge_enable_in),
  .i_bridge_direction_in(i_bridge_direction_in), .i_bridge_input_one(i_bridge_input_one),
  .i_bridge_input_two(i_bridge_input_two), .i_off_time_select(i_off_time_select),
  .o_bridge_output_one_high(o_bridge_output_one_high), .o_bridge_output_one_low(o_bridge_output_one_low),
  .o_bridge_output_two_high(o_bridge_output_two_high), .o_bridge_output_two_low(o_bridge_output_two_low),
  .o_off_time_applied(o_off_time_applied));
module tb_top;
  logic       clk, rst_n, sleep_request_low, two_input_mode;
  logic [1:0] enable_in, direction_in, input_one, input_two, off_select, decay_a, decay_b;
  logic [1:0] step_down, force_trip, trip, valley, near_zero;
  logic [1:0] one_high, one_low, two_high, two_low, off_applied;
  int         failures, compares, cycles;
  logic [3:0] exp2 [4] = '{4'h5, 4'h6, 4'h9, 4'ha};
  logic [10:0] off_time_select [4] = '{chopper_pkg::OFF_LOW_CYC, chopper_pkg::OFF_HIGH_CYC,
                            chopper_pkg::OFF_OPEN_CYC, chopper_pkg::OFF_RGND_CYC};
  dual_hbridge_chopper_control u_dual_hbridge_chopper_control (
    .i_clk(clk), .i_rst_n(rst_n), .i_sleep_request_low(sleep_request_low), .i_two_input_mode(two_input_mode),
    .i_bridge_enable_in(enable_in), .i_bridge_direction_in(direction_in), .i_bridge_input_one(input_one),
    .i_bridge_input_two(input_two), .i_off_time_select(off_select), .i_bridge_a_decay_select(decay_a),
    .i_bridge_b_decay_select(decay_b), .i_trip_current_level(trip), .i_valley_current_level(valley),
    .i_current_near_zero(near_zero), .i_target_step_down(step_down), .o_bridge_output_one_high(one_high),
    .o_bridge_output_one_low(one_low), .o_bridge_output_two_high(two_high), .o_bridge_output_two_low(two_low),
    .o_off_time_applied(off_applied));
  winding_model u_winding_model (
    .i_clk(clk), .i_rst_n(rst_n), .i_one_high(one_high), .i_one_low(one_low), .i_two_high(two_high),
    .i_two_low(two_low), .i_force_trip(force_trip), .o_trip(trip), .o_valley(valley), .o_near_zero(near_zero));
  // Clock and the hang guard.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end
  function automatic logic [3:0] pat(input int b);
    return {one_high[b], one_low[b], two_high[b], two_low[b]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s gave %0h, wanted %0h", $time, what, got, exp);
    end
  endtask
  // Waits for drive on bridge b, then counts the next decay by pattern.
  task automatic meas(input int b, output int nf, output int ns, output int no);
    int k;
    nf = 0;
    ns = 0;
    no = 0;
    k = 0;
    while (pat(b) !== 4'h9 && k < 3000) begin
      tick(1);
      k++;
    end
    while (pat(b) === 4'h9 && k < 3000) begin
      tick(1);
      k++;
    end
    while (pat(b) !== 4'h9 && k < 3000) begin
      if (pat(b) === 4'h6) nf++;
      else if (pat(b) === 4'h5) ns++;
      else no++;
      tick(1);
      k++;
    end
    chk(16'(k < 3000), 16'h1, "drive resumes");
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    int nf, ns, no, n1;
    {clk, rst_n, sleep_request_low, two_input_mode} = 4'h0;
    {enable_in, direction_in, input_one, input_two, off_select, step_down, force_trip} = 14'h0;
    decay_a = 2'h3;
    decay_b = 2'h2;
    repeat (6) @(posedge clk);
    #2;
    rst_n = 1'b1;
    tick(3);
    enable_in = 2'h3;
    direction_in = 2'h3;
    tick(6);
    chk({pat(1), pat(0)}, 16'h00, "asleep");
    $display("test sleep done");
    sleep_request_low = 1'b1;
    two_input_mode = 1'b1;
    for (int c = 0; c < 4; c++) begin
      input_one = {2{c[1]}};
      input_two = {2{c[0]}};
      tick(6);
      chk({pat(1), pat(0)}, {2{exp2[c]}}, "two input code");
    end
    $display("test two input done");
    two_input_mode = 1'b0;
    enable_in = 2'h0;
    tick(6);
    chk({pat(1), pat(0)}, 16'h00, "enable low");
    enable_in = 2'h3;
    direction_in = 2'h0;
    tick(6);
    chk({pat(1), pat(0)}, 16'h66, "reverse");
    direction_in = 2'h3;
    tick(6);
    chk({pat(1), pat(0)}, 16'h99, "forward");
    $display("test direction done");
    for (int c = 0; c < 4; c++) begin
      off_select = c[1:0];
      tick(100);
      chk(16'(off_applied), 16'(c == 0 ? 0 : c - 1), "old off-time held");
      tick(200);
      chk(16'(off_applied), 16'(c), "off-time code");
      meas(0, nf, ns, no);
      chk(16'(nf + no), 16'(off_time_select[c]), "fast decay length");
      chk(16'(no > 0 && ns == 0), 16'h1, "reversal then off");
    end
    $display("test off-time done");
    off_select = 2'h0;
    tick(300);
    decay_a = 2'h2;
    decay_b = 2'h3;
    meas(0, nf, ns, no);
    chk(16'(nf), 16'd52, "mixed fast part");
    chk(16'(ns), 16'd123, "mixed slow part");
    decay_a = 2'h1;
    meas(0, nf, ns, no);
    chk(16'(nf + no), 16'h0, "ripple no reversal");
    chk(16'(ns > 0 && ns < 175), 16'h1, "ripple ends at valley");
    $display("test decay modes done");
    decay_b = 2'h0;
    force_trip = 2'h2;
    meas(1, nf, ns, no);
    n1 = nf + no;
    meas(1, nf, ns, no);
    chk(16'(nf + no > n1), 16'h1, "overshoot adds fast");
    chk(16'(nf + ns + no), 16'(off_time_select[0]), "adaptive off-time");
    step_down = 2'h2;
    tick(3);
    step_down = 2'h0;
    meas(1, nf, ns, no);
    chk(16'(nf + no), 16'(off_time_select[0]), "step down full fast");
    force_trip = 2'h0;
    // A normal trip keeps the fraction, then a drive held past the long-drive time trims it.
    meas(1, nf, ns, no);
    n1 = nf + no;
    direction_in = 2'h1;
    tick(1100);
    direction_in = 2'h3;
    tick(3);
    force_trip = 2'h2;
    meas(1, nf, ns, no);
    chk(16'(nf + no < n1), 16'h1, "long drive cuts fast");
    force_trip = 2'h0;
    $display("test adaptive done");
    close_out();
  end
endmodule

// ==== dv/winding_model.sv ====
// Purpose: Winding current and comparator model on the bridge side.
// Assumes: Current rises in forward drive, falls fast on reversal or reverse drive, slowly in recirculation.
// Notes:   A forced trip stands in for a current overshoot.
`timescale 1ns/1ps
module winding_model (
  // Clock, reset and switch commands.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [1:0] i_one_high,
  input  wire logic [1:0] i_one_low,
  input  wire logic [1:0] i_two_high,
  input  wire logic [1:0] i_two_low,
  input  wire logic [1:0] i_force_trip,
  // Comparator outputs.
  output logic      [1:0] o_trip,
  output logic      [1:0] o_valley,
  output logic      [1:0] o_near_zero
);
  int cur [2];
  int tick;
  // Integrate the winding current from the switch pattern.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur  <= '{0, 0};
      tick <= 0;
    end else begin
      tick <= tick + 1;
      for (int b = 0; b < 2; b++) begin
        if (i_one_high[b] && i_two_low[b]) cur[b] <= cur[b] + 1;
        else if (i_one_low[b] && i_two_high[b] && cur[b] > 0) cur[b] <= cur[b] - 1;
        else if (i_one_low[b] && i_two_low[b] && cur[b] > 0 && tick % 8 == 0) cur[b] <= cur[b] - 1;
      end
    end
  end
  // Comparator levels from the modelled current.
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      o_trip[b]      = i_force_trip[b] || cur[b] >= 60;
      o_valley[b]    = cur[b] <= 50;
      o_near_zero[b] = cur[b] <= 2;
    end
  end
endmodule
